// ---- hw/dscs_pkg.sv ----
// Purpose: shared constants and types of the dac serial command slave
// Assumes: one clock domain, hclk at 250 MHz
// Notes:   register offsets are byte addresses on the ahb-lite bus
package dscs_pkg;
  // ------------------------------------------------------------
  // bus register map
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_DAC    = 8'h00;   // dac register and power-down
  localparam logic [7:0] OFS_INPUT  = 8'h04;   // input register
  localparam logic [7:0] OFS_CTRL   = 8'h08;   // slave enable
  localparam logic [7:0] OFS_STATUS = 8'h0C;   // link state
  localparam logic [7:0] OFS_MASK   = 8'hFC;   // decoded address bits

  // ------------------------------------------------------------
  // reset values and field positions
  // ------------------------------------------------------------
  localparam logic [9:0] RST_CODE   = 10'h000; // register contents at reset
  localparam logic [1:0] RST_PD     = 2'h0;    // powered up at reset
  localparam logic       RST_EN     = 1'b1;    // slave listens at reset
  localparam int         POS_PD     = 16;      // power-down field in OFS_DAC
  localparam int         POS_GATED  = 0;       // status: clock gated away
  localparam int         POS_BUSY   = 1;       // status: frame in progress
  localparam logic [3:0] BITS_BYTE  = 4'h8;    // bits before an ack slot
  // upper six address bits; value is arbitrary
  localparam logic [5:0] ADDR_UPPER = 6'h15;

  // ------------------------------------------------------------
  // commands (upper nibble of the command byte)
  // ------------------------------------------------------------
  localparam logic [3:0] CMD_LOAD_BOTH = 4'hC;
  localparam logic [3:0] CMD_LOAD_IN   = 4'hD;
  localparam logic [3:0] CMD_LOAD_SWAP = 4'hE;
  localparam logic [3:0] CMD_UPDATE    = 4'hF;
  localparam logic [1:0] CMD_GRP_READ  = 2'h2;
  localparam logic [1:0] CMD_GRP_PD    = 2'h1;

  // protocol states, gray along idle-rx-ack-tx-txack
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_RX    = 3'h1,
    ST_ACK   = 3'h3,
    ST_TX    = 3'h2,
    ST_TXACK = 3'h6,
    ST_GATED = 3'h4
  } dscs_state_e;

  // a complete two-byte write frame
  typedef struct packed {
    logic [3:0] cmd;                           // command_bit_3..0
    logic [9:0] data;                          // dac_data_msb..lsb
    logic [1:0] sub;                           // sub_bit_hi, sub_bit_lo
  } dscs_frame_s;

  // ahb address phase held for the data phase
  typedef struct packed {
    logic       wr;
    logic [7:0] ofs;
  } dscs_aphase_s;
endpackage

// ---- hw/dscs_top.sv ----
// Purpose: two-wire serial slave and command decoder of a 10-bit dac
// Assumes: scl and sda arrive synchronous to hclk; hclk far above scl
// Notes:   sda is open drain: sda_oe high pulls the line low via sda_o
//
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module dscs_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        addr_sel,
  output logic      [9:0]  dac_code,
  output logic      [1:0]  powerdown_sel,
  output logic             scl_gated
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  dscs_pkg::dscs_state_e  st_q;        // protocol state
  dscs_pkg::dscs_frame_s  frame;       // assembled write frame
  dscs_pkg::dscs_aphase_s ap_q;        // latched address phase
  logic       scl_q, sda_q;            // previous pin samples
  logic [7:0] rx_q;                    // receive shifter
  logic [7:0] tx_q;                    // transmit shifter
  logic [7:0] hi_q;                    // first byte of write frame
  logic [3:0] cnt_q;                   // bits seen in this byte
  logic [1:0] idx_q;                   // 0 address, 1 first, 2 second
  logic       rw_q;                    // direction of this frame
  logic       start_hi_q;              // start seen in this scl high
  logic       busy_q;                  // between start and stop
  logic       en_q;                    // slave enable from software
  logic [9:0] inp_q, dac_q;            // input and dac registers
  logic [1:0] pd_q;                    // power-down select
  logic       gated_q;                 // clock gated after mismatch
  logic       sda_oe_q;                // ack or data low drive
  logic [31:0] rdata_q;                // read data for the data phase
  logic       rise, fall, start, stop; // bus events
  logic       commit;                  // one-cycle register load

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  // own address check; general call and ten-bit headers never match
  function automatic logic addr_ok(input logic [6:0] a, input logic sel);
    addr_ok = (a == {dscs_pkg::ADDR_UPPER, sel})
              && (a != 7'h00)
              && (a[6:2] != 5'h1E);
  endfunction

  // register offset of a bus address; shared by the write latch
  // and the read mux so the two decodes can never disagree
  function automatic logic [7:0] reg_ofs(input logic [7:0] a);
    reg_ofs = a & dscs_pkg::OFS_MASK;
  endfunction

  // read-back byte: dac bits in write-frame positions
  function automatic logic [7:0] rd_byte(input logic [9:0] d, input logic second);
    rd_byte = second ? {d[5:0], 2'h0} : {4'h0, d[9:6]};
  endfunction

  // ------------------------------------------------------------
  // bus event detection
  // ------------------------------------------------------------
  assign rise  = scl_i & ~scl_q;
  assign fall  = ~scl_i & scl_q;
  assign start = scl_i & scl_q & sda_q & ~sda_i & en_q;
  // a stop inside the pulse of its own start is not legal
  assign stop  = scl_i & scl_q & ~sda_q & sda_i & ~start_hi_q;
  assign frame = {hi_q, rx_q};

  // commit only at the falling edge closing the second byte's ack;
  // stop or start earlier simply never reaches this term
  assign commit = fall && (st_q == dscs_pkg::ST_ACK)
                  && (idx_q == 2'h2) && !rw_q;

  // pin samples, used as the previous level for edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // start within the current scl high pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_hi_q <= 1'b0;
    end else if (start) begin
      start_hi_q <= 1'b1;
    end else if (fall) begin
      start_hi_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // serial protocol engine
  // ------------------------------------------------------------
  // edges only act outside idle and gated: that is the core clock gate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q     <= dscs_pkg::ST_IDLE;
      rx_q     <= 8'h00;
      tx_q     <= 8'h00;
      hi_q     <= 8'h00;
      cnt_q    <= 4'h0;
      idx_q    <= 2'h0;
      rw_q     <= 1'b0;
      busy_q   <= 1'b0;
      gated_q  <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (start) begin
      // fresh frame, any partial write is dropped
      st_q     <= dscs_pkg::ST_RX;
      gated_q  <= 1'b0;
      cnt_q    <= 4'h0;
      idx_q    <= 2'h0;
      busy_q   <= 1'b1;
      sda_oe_q <= 1'b0;
    end else if (stop) begin
      st_q     <= dscs_pkg::ST_IDLE;
      busy_q   <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      case (st_q)
        dscs_pkg::ST_RX: begin
          if (rise) begin
            rx_q  <= {rx_q[6:0], sda_i};
            cnt_q <= cnt_q + 4'h1;
          end else if (fall && cnt_q == dscs_pkg::BITS_BYTE) begin
            if (idx_q != 2'h0) begin
              sda_oe_q <= 1'b1;
              st_q     <= dscs_pkg::ST_ACK;
            end else if (addr_ok(rx_q[7:1], addr_sel)) begin
              rw_q     <= rx_q[0];
              sda_oe_q <= 1'b1;
              st_q     <= dscs_pkg::ST_ACK;
            end else begin
              gated_q  <= 1'b1;
              st_q     <= dscs_pkg::ST_GATED;
            end
          end
        end
        dscs_pkg::ST_ACK: begin
          if (fall) begin
            cnt_q <= 4'h0;
            if (rw_q) begin
              // direction turns after the address ack
              tx_q     <= rd_byte(dac_q, 1'b0);
              // first byte opens with a zero pad bit: line stays pulled
              sda_oe_q <= 1'b1;
              idx_q    <= 2'h1;
              st_q     <= dscs_pkg::ST_TX;
            end else begin
              sda_oe_q <= 1'b0;
              if (idx_q == 2'h1) begin
                hi_q <= rx_q;
              end
              // continuous writes: pairs repeat until stop
              idx_q <= (idx_q == 2'h1) ? 2'h2 : 2'h1;
              st_q  <= dscs_pkg::ST_RX;
            end
          end
        end
        dscs_pkg::ST_TX: begin
          // bits leave msb first, changed only while scl is low
          if (rise) begin
            cnt_q <= cnt_q + 4'h1;
          end else if (fall) begin
            if (cnt_q == dscs_pkg::BITS_BYTE) begin
              sda_oe_q <= 1'b0;                                // release for ack
              st_q     <= dscs_pkg::ST_TXACK;
            end else begin
              tx_q     <= {tx_q[6:0], 1'b0};
              sda_oe_q <= ~tx_q[6];
            end
          end
        end
        dscs_pkg::ST_TXACK: begin
          if (rise) begin
            if (sda_i || idx_q == 2'h2) begin
              // nack or end of word: wait for stop or start
              st_q <= dscs_pkg::ST_IDLE;
            end else begin
              tx_q  <= rd_byte(dac_q, 1'b1);
              idx_q <= 2'h2;
            end
          end else if (fall) begin
            cnt_q    <= 4'h0;
            sda_oe_q <= ~tx_q[7];
            st_q     <= dscs_pkg::ST_TX;
          end
        end
        dscs_pkg::ST_IDLE: begin
          // no frame for us: scl edges are ignored until a start
          st_q <= dscs_pkg::ST_IDLE;
        end
        dscs_pkg::ST_GATED: begin
          st_q <= dscs_pkg::ST_GATED;
        end
        default: begin
          st_q <= dscs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // input, dac and power-down registers
  // ------------------------------------------------------------
  // power-down never touches the code registers, so wake-up restores
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      inp_q <= dscs_pkg::RST_CODE;
      dac_q <= dscs_pkg::RST_CODE;
      pd_q  <= dscs_pkg::RST_PD;
    end else if (commit) begin
      // the frame is complete here; decode its command nibble
      case (frame.cmd)
        dscs_pkg::CMD_LOAD_BOTH: begin
          inp_q <= frame.data;
          dac_q <= frame.data;
        end
        dscs_pkg::CMD_LOAD_IN: begin
          inp_q <= frame.data;
        end
        dscs_pkg::CMD_LOAD_SWAP: begin
          inp_q <= frame.data;
          dac_q <= inp_q;
        end
        dscs_pkg::CMD_UPDATE: begin
          dac_q <= inp_q;
        end
        default: begin
          if (frame.cmd[3:2] == dscs_pkg::CMD_GRP_PD) begin
            pd_q <= frame.data[9:8];
          end
          // read request group and 00xx leave everything alone
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ------------------------------------------------------------
  // address phase: latch write target, prepare read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q    <= '0;
      rdata_q <= 32'h0000_0000;
    end else if (hsel && hready && htrans[1]) begin
      ap_q.wr  <= hwrite;
      ap_q.ofs <= reg_ofs(haddr[7:0]);
      case (reg_ofs(haddr[7:0]))
        dscs_pkg::OFS_DAC:    rdata_q <= {14'h0000, pd_q, 6'h00, dac_q};
        dscs_pkg::OFS_INPUT:  rdata_q <= {22'h000000, inp_q};
        dscs_pkg::OFS_CTRL:   rdata_q <= {31'h00000000, en_q};
        dscs_pkg::OFS_STATUS: rdata_q <= {30'h00000000, busy_q, gated_q};
        default:              rdata_q <= 32'h0000_0000; // unmapped reads zero
      endcase
    end else begin
      ap_q.wr <= 1'b0;
    end
  end

  // data phase write; only the enable is writable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q <= dscs_pkg::RST_EN;
    end else if (ap_q.wr && ap_q.ofs == dscs_pkg::OFS_CTRL) begin
      en_q <= hwdata[0];
    end
  end

  // ------------------------------------------------------------
  // output flops
  // ------------------------------------------------------------
  // every pin leaves from a flop; sda_o fixed low for open drain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
      sda_o         <= 1'b0;
      sda_oe        <= 1'b0;
      dac_code      <= dscs_pkg::RST_CODE;
      powerdown_sel <= dscs_pkg::RST_PD;
      scl_gated     <= 1'b0;
    end else begin
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
      sda_o         <= 1'b0;
      sda_oe        <= sda_oe_q;
      dac_code      <= dac_q;
      powerdown_sel <= pd_q;
      scl_gated     <= gated_q;
    end
  end

  // read data register is itself the output flop
  assign hrdata = rdata_q;

  // hsize is accepted as word only; unused bits kept visible here
  logic unused_ok;
  assign unused_ok = &{1'b0, hsize, haddr[31:8], hwdata[31:1], frame.sub};

endmodule

`default_nettype wire

// ---- verification/dscs_properties.sv ----
// Purpose: port checker of the dac serial command slave
// Assumes: scl_i and sda_i synchronous to hclk
// Notes:   bound to dscs_top below the module
`timescale 1ns/1ps
`default_nettype none
module dscs_properties (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic [9:0] dac_code,
  input wire logic [1:0] powerdown_sel,
  input wire logic       scl_gated
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // device starts pulling sda
  sequence s_pull_start;
    $rose(sda_oe);
  endsequence
  // sda was pulled for an ack slot four cycles back
  sequence s_ack_seen;
    $past(sda_oe, 4);
  endsequence
  a_pull_only: assert property (sda_o == 1'b0)
    else $error("sda driven high");
  a_turn_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("sda moved while scl high");
  a_pull_hold: assert property (s_pull_start |-> sda_oe [*8])
    else $error("pull shorter than half an scl period");
  a_gated_quiet: assert property (scl_gated |-> !sda_oe)
    else $error("gated slave drives sda");
  a_ungate_start: assert property ($fell(scl_gated) |-> scl_i && !sda_i)
    else $error("gating left without start");
  a_code_on_fall: assert property ($changed(dac_code) |-> !scl_i && !$past(scl_i, 2))
    else $error("dac code moved outside scl low");
  a_code_in_ack: assert property ($changed(dac_code) |-> s_ack_seen)
    else $error("dac code moved without ack");
  a_pd_keeps_code: assert property ($changed(powerdown_sel) |-> $stable(dac_code))
    else $error("power-down change altered dac code");
endmodule
bind dscs_top dscs_properties u_props (
  .hclk          (hclk),
  .hresetn       (hresetn),
  .scl_i         (scl_i),
  .sda_i         (sda_i),
  .sda_o         (sda_o),
  .sda_oe        (sda_oe),
  .dac_code      (dac_code),
  .powerdown_sel (powerdown_sel),
  .scl_gated     (scl_gated)
);
`default_nettype wire

// ---- verification/dscs_master.sv ----
// Purpose: two-wire bus master model facing the slave
// Assumes: scl half period of 8 hclk cycles
// Notes:   open drain: sda_low pulls the wired line low
`timescale 1ns/1ps
`default_nettype none
module dscs_master (
  input  wire logic hclk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_low
);
  // idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // one clock pulse; data changes only while scl low
  task automatic bit_io(input logic b, output logic r);
    sda_low <= !b;
    tick(4);
    scl <= 1'b1;
    tick(8);
    r = sda;
    scl <= 1'b0;
    tick(4);
  endtask
  // start, always a full pulse away from any stop
  task automatic start();
    sda_low <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(8);
    sda_low <= 1'b1;
    tick(8);
    scl <= 1'b0;
    tick(4);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(8);
    sda_low <= 1'b0;
    tick(8);
  endtask
  // msb first byte, then ninth slot: mb is master ack level
  task automatic xfer(input logic [7:0] tx, input logic mb,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(mb, ack);
  endtask
endmodule
`default_nettype wire

// ---- verification/dscs_top_test.sv ----
// Purpose: self-checking bench of the dac serial command slave
// Assumes: hready looped from hreadyout, one slave
// Notes:   expected values kept in pd and tracked codes
`timescale 1ns/1ps
`default_nettype none
module dscs_top_test;
  logic        hclk, hresetn, hsel, hwrite, a0, sda_oe, sda_o, scl, sda_low, sda, hreadyout;
  logic        hresp, scl_gated;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, pd, powerdown_sel;
  logic [2:0]  hsize;
  logic [9:0]  dac_code;
  int          errors, samples_checked, cyc;
  wire  [6:0]  dev = {dscs_pkg::ADDR_UPPER, a0};
  assign sda = !(sda_oe | sda_low); // pull-up wins when released
  dscs_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .addr_sel(a0),
    .dac_code(dac_code), .powerdown_sel(powerdown_sel), .scl_gated(scl_gated));
  dscs_master m (.hclk(hclk), .sda(sda), .scl(scl), .sda_low(sda_low));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task automatic summarize();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      summarize();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // one single ahb transfer, address then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
    // hsel stays up: with htrans idle the slave ignores it, and a
    // following call raises nothing that was just lowered
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    chk("bus read", e, v);
  endtask
  task automatic regs(input logic [9:0] dv, input logic [9:0] iv);
    chk("dac_code", {22'h0, dv}, {22'h0, dac_code});
    chk("powerdown_sel", {30'h0, pd}, {30'h0, powerdown_sel});
    rdchk(dscs_pkg::OFS_DAC, {14'h0, pd, 6'h0, dv});
    rdchk(dscs_pkg::OFS_INPUT, {22'h0, iv});
  endtask
  // write frame; ab cuts it after the command byte
  task automatic frame(input logic [3:0] c, input logic [9:0] d, input logic ab);
    logic [7:0] r;
    logic       k;
    m.start();
    m.xfer({dev, 1'b0}, 1'b1, r, k);
    chk("addr ack", 32'h0, {31'h0, k});
    m.xfer({c, d[9:6]}, 1'b1, r, k);
    chk("cmd ack", 32'h0, {31'h0, k});
    if (!ab) begin
      m.xfer({d[5:0], 2'b00}, 1'b1, r, k);
      chk("data ack", 32'h0, {31'h0, k});
    end
    m.stop();
  endtask
  task automatic t_map();
    logic [31:0] v;
    logic [7:0]  r;
    logic        k;
    rdchk(dscs_pkg::OFS_CTRL, 32'h1);
    rdchk(dscs_pkg::OFS_STATUS, 32'h0);
    rdchk(8'h10, 32'h0);
    ahb(1'b1, dscs_pkg::OFS_DAC, 32'h3FF, v);
    regs(10'h000, 10'h000);
    ahb(1'b1, dscs_pkg::OFS_CTRL, 32'h0, v);
    rdchk(dscs_pkg::OFS_CTRL, 32'h0);
    m.start();
    m.xfer({dev, 1'b0}, 1'b1, r, k);
    chk("disabled ack", 32'h1, {31'h0, k});
    m.stop();
    ahb(1'b1, dscs_pkg::OFS_CTRL, 32'h1, v);
  endtask
  task automatic t_cmds();
    frame(dscs_pkg::CMD_LOAD_BOTH, 10'h155, 1'b0);
    regs(10'h155, 10'h155);
    frame(dscs_pkg::CMD_LOAD_IN, 10'h2AA, 1'b0);
    regs(10'h155, 10'h2AA);
    frame(dscs_pkg::CMD_LOAD_SWAP, 10'h0F0, 1'b0);
    regs(10'h2AA, 10'h0F0);
    frame(dscs_pkg::CMD_UPDATE, 10'h3FF, 1'b0);
    regs(10'h0F0, 10'h0F0);
    frame(4'h9, 10'h3FF, 1'b0);
    regs(10'h0F0, 10'h0F0);
    frame(dscs_pkg::CMD_LOAD_BOTH, 10'h3FF, 1'b1);
    regs(10'h0F0, 10'h0F0);
  endtask
  // modes 1,2,3 then power up
  task automatic t_pd();
    for (int n = 1; n < 5; n++) begin
      pd = n[1:0];
      frame(4'h4, {pd, 8'hA5}, 1'b0);
      regs(10'h0F0, 10'h0F0);
    end
  endtask
  task automatic t_read();
    logic [7:0] r;
    logic       k;
    m.start();
    m.xfer({dev, 1'b1}, 1'b1, r, k);
    chk("read addr ack", 32'h0, {31'h0, k});
    m.xfer(8'hFF, 1'b0, r, k);
    chk("read byte1", 32'h03, {24'h0, r});
    m.xfer(8'hFF, 1'b1, r, k);
    chk("read byte2", 32'hC0, {24'h0, r});
    m.stop();
  endtask
  // other lsb, general call, ten-bit prefix
  task automatic t_gate();
    logic [6:0] bad [3];
    logic [7:0] r;
    logic       k;
    bad = '{{dscs_pkg::ADDR_UPPER, ~a0}, 7'h00, 7'h78};
    foreach (bad[i]) begin
      m.start();
      m.xfer({bad[i], 1'b0}, 1'b1, r, k);
      chk("foreign ack", 32'h1, {31'h0, k});
      chk("scl_gated", 32'h1, {31'h0, scl_gated});
      // gated, and still busy until the stop that follows
      rdchk(dscs_pkg::OFS_STATUS, 32'h3);
      m.stop();
    end
    a0 <= ~a0;
    frame(dscs_pkg::CMD_LOAD_BOTH, 10'h2AA, 1'b0);
    chk("scl_gated", 32'h0, {31'h0, scl_gated});
    regs(10'h2AA, 10'h2AA);
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    a0 = 1'b1;
    pd = 2'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_map();
    t_cmds();
    t_pd();
    t_read();
    t_gate();
    summarize();
  end
endmodule
`default_nettype wire
